// ===== rtl/secer_consts.svh
// constants of the secure erase command handler: codes, bit positions, timings
`ifndef SECER_CONSTS_SVH
`define SECER_CONSTS_SVH

// =====================================================================
// command codes
`define SECER_CMD_ERASE_PREPARE 8'hf3
`define SECER_CMD_ERASE_UNIT 8'hf4
`define SECER_CMD_FORMAT_UNIT 8'h50

// =====================================================================
// status bit positions
`define SECER_ST_BUSY 7
`define SECER_ST_READY 6
`define SECER_ST_FAULT 5
`define SECER_ST_SEEK_DONE 4
`define SECER_ST_DRQ 3
`define SECER_ST_CORRECTED 2
`define SECER_ST_INDEX 1
`define SECER_ST_ERROR 0

// =====================================================================
// error bit positions
`define SECER_ERR_ID_MISSING 4
`define SECER_ERR_ABORTED 2

// =====================================================================
// parameter sector layout
`define SECER_SECTOR_WORDS 256
`define SECER_LAST_WORD 9'h0ff
`define SECER_PW_FIRST_WORD 8'h01
`define SECER_PW_LAST_WORD 8'h10
`define SECER_CTRL_SEL_MASTER 0
`define SECER_CTRL_ENHANCED 1

// =====================================================================
// identification word 89: erase time in two-minute units
`define SECER_ID_ERASE_TIME 16'h003c

// =====================================================================
// host register offsets
`define SECER_REG_COMMAND 8'h00
`define SECER_REG_CONTROL 8'h01
`define SECER_REG_PW_BASE 8'h02
`define SECER_REG_PW_LAST 8'h11
`define SECER_REG_STATUS 8'h12

// =====================================================================
// reset values
`define SECER_STATUS_RESET 8'h50
`define SECER_ERROR_RESET 8'h00

`endif

// ===== rtl/secer_pkg.sv
// types of the secure erase command handler
`default_nettype none

package secer_pkg;

  // =====================================================================
  // device command sequencer states
  typedef enum logic [2:0] {
    SECER_DEV_IDLE = 3'b000,
    SECER_DEV_PARAM = 3'b001,
    SECER_DEV_CHECK = 3'b010,
    SECER_DEV_ERASE = 3'b011,
    SECER_DEV_FINISH = 3'b100
  } secer_dev_state_type;

  // =====================================================================
  // host sequencer states
  typedef enum logic [1:0] {
    SECER_HST_IDLE = 2'b00,
    SECER_HST_WAIT = 2'b01,
    SECER_HST_SEND = 2'b10
  } secer_hst_state_type;

endpackage : secer_pkg

`default_nettype wire

// ===== rtl/secer_if.sv
// link between host adapter and drive command handler
`timescale 1ns/1ps
`default_nettype none

interface secer_if;
  logic cmd_strobe;
  logic [7:0] cmd_code;
  logic data_strobe;
  logic [15:0] data_word;
  logic busy;
  logic drq;
  logic [7:0] command_status_flags;
  logic [7:0] command_error_flags;

  modport dev (
    input cmd_strobe, cmd_code, data_strobe, data_word,
    output busy, drq, command_status_flags, command_error_flags
  );

  modport hst (
    output cmd_strobe, cmd_code, data_strobe, data_word,
    input busy, drq, command_status_flags, command_error_flags
  );
endinterface : secer_if

`default_nettype wire

// ===== rtl/secer_pw_compare.sv
// password comparator fed word by word from the parameter sector
`timescale 1ns/1ps
`default_nettype none
`include "secer_consts.svh"

module secer_pw_compare #(
  parameter int PW_WORDS = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // stream
  input wire logic clear,
  input wire logic word_valid,
  input wire logic [7:0] word_index,
  input wire logic [15:0] word_data,
  input wire logic select_master,
  // stored passwords
  input wire logic [PW_WORDS*16-1:0] user_password,
  input wire logic [PW_WORDS*16-1:0] master_password,
  // result
  output logic match
);

  logic match_q;
  logic match_d;
  wire logic in_pw = (word_index >= `SECER_PW_FIRST_WORD) && (word_index <= `SECER_PW_LAST_WORD);
  wire logic [7:0] slot = word_index - `SECER_PW_FIRST_WORD;
  wire logic [PW_WORDS*16-1:0] target = select_master ? master_password : user_password;
  wire logic [15:0] expect_word = target[slot*16 +: 16];
  wire logic word_ok = (expect_word == word_data);

  always_comb begin
    match_d = match_q;
    if (clear) begin
      match_d = 1'b1;
    end else if (word_valid && in_pw && !word_ok) begin
      match_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      match_q <= 1'b0;
    end else begin
      match_q <= match_d;
    end
  end

  assign match = match_q;

endmodule : secer_pw_compare

`default_nettype wire

// ===== rtl/secer_device.sv
// drive end: erase-prepare and erase-unit command handling
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "secer_consts.svh"

// Notes on behaviour
// - erase-prepare completes without data transfer
// - erase-unit takes exactly one parameter sector
// - erase-unit needs preceding erase-prepare, with only format-unit allowed between
// - host also prepares before format-unit
// - password mismatch aborts erase-unit
// - control bit 0 picks user or master
// - bit 1 enhanced unsupported, bits 2-15 reserved
// - words 1-16 password, 17-255 ignored
// - erase LBA zero to native limit
// - zeros written, no read-back
// - defect and reassign lists untouched
// - success disables lock, master kept
// - lock disabled skips password check
// - erase time reported in word 89
// - frozen state rejects erase-unit
module secer_device #(
  parameter int LBA_WIDTH = 32,
  parameter int PW_WORDS = 16,
  parameter logic [15:0] ERASE_TIME_UNITS = `SECER_ID_ERASE_TIME
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // host link
  secer_if.dev link,
  // security state
  input wire logic lock_enabled,
  input wire logic frozen,
  input wire logic [PW_WORDS*16-1:0] user_password,
  input wire logic [PW_WORDS*16-1:0] master_password,
  output logic lock_disable,
  // capacity
  input wire logic [LBA_WIDTH-1:0] native_capacity_limit,
  // media write port
  output logic media_wr_valid,
  input wire logic media_wr_ready,
  output logic [LBA_WIDTH-1:0] media_wr_lba,
  output logic [15:0] media_wr_data,
  // identification data
  output logic [15:0] id_erase_time_word
);

  // =====================================================================
  // state
  secer_pkg::secer_dev_state_type state_q;
  secer_pkg::secer_dev_state_type state_d;
  logic prepared_q;
  logic prepared_d;
  logic aborted_q;
  logic aborted_d;
  logic [8:0] word_idx_q;
  logic [8:0] word_idx_d;
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  logic [LBA_WIDTH-1:0] lba_q;
  logic [LBA_WIDTH-1:0] lba_d;
  logic lock_disable_q;
  logic lock_disable_d;
  logic pw_match;

  // =====================================================================
  // decode
  wire logic idle = (state_q == secer_pkg::SECER_DEV_IDLE);
  wire logic in_param = (state_q == secer_pkg::SECER_DEV_PARAM);
  wire logic cmd_take = link.cmd_strobe && idle;
  wire logic is_prepare = (link.cmd_code == `SECER_CMD_ERASE_PREPARE);
  wire logic is_erase = (link.cmd_code == `SECER_CMD_ERASE_UNIT);
  wire logic is_format = (link.cmd_code == `SECER_CMD_FORMAT_UNIT);
  wire logic word_take = in_param && link.data_strobe;
  wire logic last_word = (word_idx_q == `SECER_LAST_WORD);
  wire logic last_lba = (lba_q == native_capacity_limit);
  wire logic enhanced = ctrl_q[`SECER_CTRL_ENHANCED];

  // =====================================================================
  // password comparison
  // identifier bit selects stored password
  secer_pw_compare #(
    .PW_WORDS(PW_WORDS)
  ) u_compare (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clear(cmd_take),
    .word_valid(word_take),
    .word_index(word_idx_q[7:0]),
    .word_data(link.data_word),
    .select_master(word_idx_q == 9'h000 ? link.data_word[`SECER_CTRL_SEL_MASTER]
                                         : ctrl_q[`SECER_CTRL_SEL_MASTER]),
    .user_password(user_password),
    .master_password(master_password),
    .match(pw_match)
  );

  // =====================================================================
  // sequencer
  always_comb begin
    state_d = state_q;
    prepared_d = prepared_q;
    aborted_d = aborted_q;
    word_idx_d = word_idx_q;
    ctrl_d = ctrl_q;
    lba_d = lba_q;
    lock_disable_d = 1'b0;
    case (state_q)
      secer_pkg::SECER_DEV_IDLE: begin
        if (cmd_take) begin
          aborted_d = 1'b0;
          state_d = secer_pkg::SECER_DEV_FINISH;
          word_idx_d = 9'h000;
          if (is_prepare) begin
            prepared_d = 1'b1;
          end else if (is_erase) begin
            prepared_d = 1'b0;
            if (!prepared_q || frozen) begin
              aborted_d = 1'b1;
            end else begin
              state_d = secer_pkg::SECER_DEV_PARAM;
            end
          end else if (is_format) begin
            aborted_d = 1'b1;
          end else begin
            prepared_d = 1'b0;
            aborted_d = 1'b1;
          end
        end
      end
      secer_pkg::SECER_DEV_PARAM: begin
        if (word_take) begin
          word_idx_d = word_idx_q + 9'h001;
          if (word_idx_q == 9'h000) begin
            ctrl_d = link.data_word;
          end
          if (last_word) begin
            state_d = secer_pkg::SECER_DEV_CHECK;
          end
        end
      end
      secer_pkg::SECER_DEV_CHECK: begin
        lba_d = '0;
        if (enhanced) begin
          aborted_d = 1'b1;
          state_d = secer_pkg::SECER_DEV_FINISH;
        end else if (lock_enabled && !pw_match) begin
          aborted_d = 1'b1;
          state_d = secer_pkg::SECER_DEV_FINISH;
        end else begin
          state_d = secer_pkg::SECER_DEV_ERASE;
        end
      end
      secer_pkg::SECER_DEV_ERASE: begin
        if (media_wr_ready) begin
          if (last_lba) begin
            lock_disable_d = 1'b1;
            state_d = secer_pkg::SECER_DEV_FINISH;
          end else begin
            lba_d = lba_q + {{(LBA_WIDTH-1){1'b0}}, 1'b1};
          end
        end
      end
      secer_pkg::SECER_DEV_FINISH: begin
        state_d = secer_pkg::SECER_DEV_IDLE;
      end
      default: begin
        state_d = secer_pkg::SECER_DEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= secer_pkg::SECER_DEV_IDLE;
      prepared_q <= 1'b0;
      aborted_q <= 1'b0;
      word_idx_q <= 9'h000;
      ctrl_q <= 16'h0000;
      lba_q <= '0;
      lock_disable_q <= 1'b0;
    end else begin
      state_q <= state_d;
      prepared_q <= prepared_d;
      aborted_q <= aborted_d;
      word_idx_q <= word_idx_d;
      ctrl_q <= ctrl_d;
      lba_q <= lba_d;
      lock_disable_q <= lock_disable_d;
    end
  end

  // =====================================================================
  // outputs
  // write-only zero fill, lists untouched
  assign media_wr_valid = (state_q == secer_pkg::SECER_DEV_ERASE);
  assign media_wr_lba = lba_q;
  assign media_wr_data = 16'h0000;
  assign lock_disable = lock_disable_q;
  assign id_erase_time_word = ERASE_TIME_UNITS;

  // busy until finish, abort flags error
  assign link.busy = !idle;
  assign link.drq = in_param;
  assign link.command_status_flags = {!idle, idle, 1'b0, 1'b1, in_param, 1'b0, 1'b0,
                                      aborted_q && idle};
  assign link.command_error_flags = {5'h00, aborted_q && idle, 2'h0};

endmodule : secer_device

`default_nettype wire

// ===== rtl/secer_host.sv
// host adapter end: issues commands and sends the parameter sector
`timescale 1ns/1ps
`default_nettype none
`include "secer_consts.svh"

module secer_host #(
  parameter int PW_WORDS = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // software register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // drive link
  secer_if.hst link
);

  // =====================================================================
  // registers
  secer_pkg::secer_hst_state_type state_q;
  secer_pkg::secer_hst_state_type state_d;
  logic [15:0] pw_q [PW_WORDS];
  logic [15:0] ctrl_q;
  logic [7:0] code_q;
  logic strobe_q;
  logic [8:0] word_q;
  logic [8:0] word_d;
  logic [15:0] rdata_q;

  // =====================================================================
  // decode
  wire logic wr_cmd = reg_wr && (reg_addr == `SECER_REG_COMMAND) &&
                      (state_q == secer_pkg::SECER_HST_IDLE) && !link.busy;
  wire logic wr_ctrl = reg_wr && (reg_addr == `SECER_REG_CONTROL);
  wire logic pw_hit = (reg_addr >= `SECER_REG_PW_BASE) && (reg_addr <= `SECER_REG_PW_LAST);
  wire logic [7:0] pw_slot = reg_addr - `SECER_REG_PW_BASE;
  wire logic sending = (state_q == secer_pkg::SECER_HST_SEND) && link.drq;
  wire logic [7:0] sector_word = word_q[7:0];
  wire logic [7:0] sector_slot = sector_word - `SECER_PW_FIRST_WORD;
  wire logic in_pw = (sector_word >= `SECER_PW_FIRST_WORD) &&
                     (sector_word <= `SECER_PW_LAST_WORD);
  wire logic [15:0] send_word = (sector_word == 8'h00) ? ctrl_q :
                                in_pw ? pw_q[sector_slot[3:0]] : 16'h0000;
  wire logic [15:0] rd_value = (reg_addr == `SECER_REG_STATUS) ?
                               {link.command_error_flags, link.command_status_flags} :
                               (reg_addr == `SECER_REG_CONTROL) ? ctrl_q :
                               pw_hit ? pw_q[pw_slot[3:0]] : 16'h0000;

  // =====================================================================
  // sequencer
  always_comb begin
    state_d = state_q;
    word_d = word_q;
    case (state_q)
      secer_pkg::SECER_HST_IDLE: begin
        word_d = 9'h000;
        if (wr_cmd) begin
          state_d = secer_pkg::SECER_HST_WAIT;
        end
      end
      secer_pkg::SECER_HST_WAIT: begin
        if (link.drq) begin
          state_d = secer_pkg::SECER_HST_SEND;
        end else if (!link.busy && !strobe_q) begin
          state_d = secer_pkg::SECER_HST_IDLE;
        end
      end
      secer_pkg::SECER_HST_SEND: begin
        if (sending) begin
          word_d = word_q + 9'h001;
          if (word_q == `SECER_LAST_WORD) begin
            state_d = secer_pkg::SECER_HST_WAIT;
          end
        end
      end
      default: begin
        state_d = secer_pkg::SECER_HST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= secer_pkg::SECER_HST_IDLE;
      word_q <= 9'h000;
      strobe_q <= 1'b0;
      code_q <= 8'h00;
      ctrl_q <= 16'h0000;
      rdata_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      word_q <= word_d;
      strobe_q <= wr_cmd;
      rdata_q <= reg_rd ? rd_value : 16'h0000;
      if (wr_cmd) begin
        code_q <= reg_wdata[7:0];
      end
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata;
      end
    end
  end

  generate
    for (genvar i = 0; i < PW_WORDS; i++) begin : g_pw
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          pw_q[i] <= 16'h0000;
        end else if (reg_wr && pw_hit && (pw_slot == 8'(i))) begin
          pw_q[i] <= reg_wdata;
        end
      end
    end
  endgenerate

  // =====================================================================
  // outputs
  assign reg_rdata = rdata_q;
  assign link.cmd_strobe = strobe_q;
  assign link.cmd_code = code_q;
  assign link.data_strobe = sending;
  assign link.data_word = send_word;

endmodule : secer_host

`default_nettype wire

// ===== rtl/secer_host_dummy_never.sv
// (intentionally omitted)

// ===== testbench/secer_link_assertions.sv
// checker for the host-to-drive erase command link
`timescale 1ns/1ps
`default_nettype none
`include "secer_consts.svh"

module secer_link_assertions (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // link
  input wire logic cmd_strobe,
  input wire logic [7:0] cmd_code,
  input wire logic data_strobe,
  input wire logic [15:0] data_word,
  input wire logic busy,
  input wire logic drq,
  input wire logic [7:0] command_status_flags,
  input wire logic [7:0] command_error_flags
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // =====================================================================
  // helper: prepared state and sector word count
  logic armed_q;
  logic armed_d;
  logic [8:0] words_q;
  logic [8:0] words_d;
  wire logic take = cmd_strobe && !busy;
  wire logic word_take = data_strobe && drq;
  wire logic is_prep = cmd_code == `SECER_CMD_ERASE_PREPARE;
  wire logic is_unit = cmd_code == `SECER_CMD_ERASE_UNIT;
  wire logic is_fmt = cmd_code == `SECER_CMD_FORMAT_UNIT;
  assign armed_d = take ? (is_prep || (is_fmt && armed_q)) : armed_q;
  assign words_d = take ? 9'h000 : (word_take ? words_q + 9'h001 : words_q);
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      armed_q <= 1'b0;
      words_q <= 9'h000;
    end else begin
      armed_q <= armed_d;
      words_q <= words_d;
    end
  end

  // =====================================================================
  // properties
  property p_prep_quick;
    take && is_prep |=> busy && !drq ##1 !busy && command_error_flags == 8'h00;
  endproperty
  property p_drq_cause;
    $rose(drq) |-> $past(take) && $past(cmd_code) == `SECER_CMD_ERASE_UNIT;
  endproperty
  property p_one_sector;
    $fell(drq) |-> words_q == 9'h100;
  endproperty
  property p_unprepared;
    take && is_unit && !armed_q |=> busy && !drq ##1 !busy && command_error_flags[2];
  endproperty
  property p_cancel;
    take && !is_prep && !is_unit && !is_fmt |=> busy ##1 !busy && command_error_flags[2];
  endproperty
  property p_reserved_zero;
    word_take && words_q > 9'h010 |-> data_word == 16'h0000;
  endproperty
  property p_abort_flags;
    command_error_flags[`SECER_ERR_ABORTED] |-> !busy && command_status_flags[`SECER_ST_ERROR];
  endproperty
  property p_drq_busy;
    drq |-> busy && command_status_flags[`SECER_ST_BUSY] && command_status_flags[`SECER_ST_DRQ];
  endproperty
  property p_flags_stand;
    !busy && !cmd_strobe |=> $stable(command_error_flags);
  endproperty

  a_prep_quick: assert property (p_prep_quick) else $error("prepare not quick");
  a_drq_cause: assert property (p_drq_cause) else $error("drq without erase");
  a_one_sector: assert property (p_one_sector) else $error("sector count wrong");
  a_unprepared: assert property (p_unprepared) else $error("unprepared not aborted");
  a_cancel: assert property (p_cancel) else $error("other command not aborted");
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved word set");
  a_abort_flags: assert property (p_abort_flags) else $error("abort flags wrong");
  a_drq_busy: assert property (p_drq_busy) else $error("drq outside busy");
  a_flags_stand: assert property (p_flags_stand) else $error("flags changed idle");

  c_prep: cover property (take && is_prep);
  c_sector: cover property ($fell(drq));
  c_abort: cover property ($rose(command_error_flags[2]));
endmodule : secer_link_assertions

`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench: host adapter and drive joined over the link
`timescale 1ns/1ps
`default_nettype none
`include "secer_consts.svh"
`define CHK(nm, e, g) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("[ERR] %s exp=%0h got=%0h", nm, e, g); \
  end \
end

module tb_top;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic lock_enabled = 1'b1;
  logic frozen = 1'b0;
  logic [255:0] user_password = '0;
  logic [255:0] master_password = '0;
  logic lock_disable;
  logic [31:0] native_capacity_limit = 32'h0000_0003;
  logic media_wr_valid;
  logic media_wr_ready = 1'b0;
  logic [31:0] media_wr_lba;
  logic [15:0] media_wr_data;
  logic [15:0] id_erase_time_word;
  logic [15:0] cur_ctrl = 16'h0000;
  logic [15:0] sr;
  int n_errors = 0;
  int n_compared = 0;
  int n_media = 0;
  int n_unlock = 0;
  int exp_lba = 0;
  bit armed = 1'b0;
  bit pw_good = 1'b1;

  secer_if link_if ();
  secer_host secer_host_inst (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link(link_if));
  secer_device secer_device_inst (.clk_sys(clk_sys), .reset_n(reset_n), .link(link_if),
    .lock_enabled(lock_enabled), .frozen(frozen), .user_password(user_password),
    .master_password(master_password), .lock_disable(lock_disable),
    .native_capacity_limit(native_capacity_limit), .media_wr_valid(media_wr_valid),
    .media_wr_ready(media_wr_ready), .media_wr_lba(media_wr_lba),
    .media_wr_data(media_wr_data), .id_erase_time_word(id_erase_time_word));
  secer_link_assertions secer_link_assertions_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .cmd_strobe(link_if.cmd_strobe), .cmd_code(link_if.cmd_code),
    .data_strobe(link_if.data_strobe), .data_word(link_if.data_word), .busy(link_if.busy),
    .drq(link_if.drq), .command_status_flags(link_if.command_status_flags),
    .command_error_flags(link_if.command_error_flags));

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  // =====================================================================
  // media side: stalling acceptor and write monitor
  always @(posedge clk_sys) begin
    media_wr_ready <= ($urandom % 4) != 0;
    if (reset_n && media_wr_valid === 1'b1 && media_wr_ready) begin
      `CHK("lba", 32'(exp_lba), media_wr_lba)
      `CHK("fill", 16'h0000, media_wr_data)
      n_media++;
      exp_lba++;
    end
    if (lock_disable === 1'b1) n_unlock++;
  end

  // =====================================================================
  // register port tasks
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // one command with its expected outcome from the bench model
  task automatic cmd(input logic [7:0] code);
    int guard;
    bit ran;
    bit command_aborted_flag;
    ran = 1'b0;
    command_aborted_flag = code != `SECER_CMD_ERASE_PREPARE;
    if (code == `SECER_CMD_ERASE_UNIT) begin
      ran = armed && !frozen && !cur_ctrl[1] && (!lock_enabled || pw_good);
      command_aborted_flag = !ran;
    end
    armed = code == `SECER_CMD_ERASE_PREPARE || (code == `SECER_CMD_FORMAT_UNIT && armed);
    n_media = 0;
    n_unlock = 0;
    exp_lba = 0;
    wr(`SECER_REG_COMMAND, {8'h00, code});
    repeat (2) @(posedge clk_sys);
    #1 guard = 0;
    while (link_if.busy === 1'b1 && guard < 5000) begin
      @(posedge clk_sys);
      #1 guard++;
    end
    `CHK("busy", 1'b0, link_if.busy)
    rd(`SECER_REG_STATUS, sr);
    `CHK("status", command_aborted_flag ? 16'h0451 : 16'h0050, sr)
    `CHK("writes", ran ? int'(native_capacity_limit) + 1 : 0, n_media)
    `CHK("unlock", ran ? 1 : 0, n_unlock)
  endtask : cmd

  // loads control word and password, then runs the sequence
  task automatic seq(input bit prep, input logic [7:0] mid, input logic [15:0] ctrl,
                     input bit good, input bit lk, input bit frz);
    logic [255:0] sent;
    @(posedge clk_sys);
    lock_enabled <= lk;
    frozen <= frz;
    native_capacity_limit <= 32'($urandom % 8);
    cur_ctrl = ctrl;
    pw_good = good;
    sent = ctrl[0] ? master_password : user_password;
    if (!good) sent[$urandom % 256] ^= 1'b1;
    wr(`SECER_REG_CONTROL, ctrl);
    for (int k = 0; k < 16; k++) wr(`SECER_REG_PW_BASE + 8'(k), sent[k*16 +: 16]);
    if (prep) cmd(`SECER_CMD_ERASE_PREPARE);
    if (mid != 8'h00) cmd(mid);
    cmd(`SECER_CMD_ERASE_UNIT);
  endtask : seq

  task automatic test_done;
    $display("errors=%0d compared=%0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    $display("[ERR] watchdog exp=done got=hang");
    test_done();
  end

  // =====================================================================
  // main sequence
  initial begin
    void'($urandom(6));
    user_password <= {8{$urandom}};
    master_password <= {8{$urandom}};
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(`SECER_REG_STATUS, sr);
    `CHK("reset", 16'h0050, sr)
    rd(8'h40, sr);
    `CHK("unmapped", 16'h0000, sr)
    `CHK("erase_time", `SECER_ID_ERASE_TIME, id_erase_time_word)
    seq(1'b0, 8'h00, 16'h0000, 1'b1, 1'b1, 1'b0);
    seq(1'b1, 8'h00, 16'h0000, 1'b1, 1'b1, 1'b0);
    seq(1'b1, 8'h00, 16'h0000, 1'b0, 1'b1, 1'b0);
    seq(1'b1, 8'h00, 16'h0001, 1'b1, 1'b1, 1'b0);
    seq(1'b1, 8'h00, 16'h0001, 1'b0, 1'b1, 1'b0);
    seq(1'b1, 8'h00, 16'h0002, 1'b1, 1'b1, 1'b0);
    seq(1'b1, 8'h00, 16'hfffc, 1'b1, 1'b1, 1'b0);
    seq(1'b1, 8'h00, 16'h0000, 1'b0, 1'b0, 1'b0);
    seq(1'b1, 8'h00, 16'h0000, 1'b1, 1'b1, 1'b1);
    seq(1'b1, 8'hec, 16'h0000, 1'b1, 1'b1, 1'b0);
    seq(1'b1, 8'h50, 16'h0000, 1'b1, 1'b1, 1'b0);
    test_done();
  end
endmodule : tb_top

`default_nettype wire
